// ==== include/fdiv_pkg.sv ====
package fdiv_pkg;
	localparam int FRAME_BITS = 34;
	localparam int HDR_BITS = 10;
	localparam int DATA_W = 24;
	localparam int CHIP_W = 3;
	localparam int REG_W = 6;
	localparam logic [5:0] REG_IDENT = 6'h00;
	localparam logic [5:0] REG_REFDIV = 6'h02;
	localparam logic [5:0] REG_INT = 6'h05;
	localparam logic [5:0] REG_FRAC = 6'h06;
	localparam logic [5:0] REG_COMP = 6'h09;
	localparam logic [5:0] REG_MODE = 6'h1f;
	localparam logic [5:0] COMP_REFDIV_REG = 6'h02;
	localparam int PW_LSB = 12;
	localparam int PW_W = 3;
	localparam int SOFT_RST_BIT = 5;
	localparam int MODE_FRAC_BIT = 0;
	localparam int MODE_RUN_BIT = 1;
	localparam int INT_W = 20;
	localparam int REFDIV_W = 14;
	localparam int FRAC_W = 24;
	localparam logic [2:0] PW_RST = 3'h3;
	localparam logic [19:0] INT_RST = 20'h00020;
	localparam logic [13:0] REFDIV_RST = 14'h0001;
	localparam logic [23:0] FRAC_RST = 24'h000000;
	localparam logic [2:0] STRAP_RST = 3'h7;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [1:0] MODE_RST = 2'h2;
	localparam logic [20:0] INT_MIN = 21'h000020;
	localparam logic [20:0] INT_MAX = 21'h0fffff;
	localparam logic [20:0] FRAC_MIN = 21'h000024;
	localparam logic [20:0] FRAC_MAX = 21'h0ffffb;
endpackage

// ==== include/frame_if.sv ====
`timescale 1ns/1ps
interface frame_if;
	logic hdr_stb;
	logic wr_stb;
	logic rd;
	logic active;
	logic sdo;
	logic [2:0] chip;
	logic [5:0] regad;
	logic [23:0] wdata;
	logic [23:0] rdata;
	modport rx
	(
		output hdr_stb, wr_stb, rd, active, sdo, chip, regad, wdata,
		input rdata
	);
	modport core
	(
		input hdr_stb, wr_stb, rd, active, sdo, chip, regad, wdata,
		output rdata
	);
endinterface

// ==== core/spi_frame_rx.sv ====
`timescale 1ns/1ps
module spi_frame_rx
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sck_i,
	input wire logic sdi_i,
	input wire logic csn_i,
	frame_if.rx fr
);
	logic [1:0] sck_m, sdi_m, csn_m;
	logic sck_d;
	logic [5:0] bitcnt;
	logic [32:0] shreg;
	logic [23:0] txsh;
	logic rise, fall, sel;

	// Pins are asynchronous; the first stage feeds only the second.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sck_m <= 2'h0;
			sdi_m <= 2'h0;
			csn_m <= 2'h3;
			sck_d <= 1'b0;
		end
		else
		begin
			sck_m <= {sck_m[0], sck_i};
			sdi_m <= {sdi_m[0], sdi_i};
			csn_m <= {csn_m[0], csn_i};
			sck_d <= sck_m[1];
		end
	end

	assign rise = sck_m[1] & ~sck_d;
	assign fall = ~sck_m[1] & sck_d;
	assign sel = ~csn_m[1];
	assign fr.active = sel;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bitcnt <= 6'h00;
			shreg <= 33'h0;
			fr.hdr_stb <= 1'b0;
			fr.wr_stb <= 1'b0;
			fr.rd <= 1'b0;
			fr.chip <= 3'h0;
			fr.regad <= 6'h00;
			fr.wdata <= 24'h000000;
		end
		else
		begin
			fr.hdr_stb <= 1'b0;
			fr.wr_stb <= 1'b0;
			if (!sel)
			begin
				bitcnt <= 6'h00;
				fr.rd <= 1'b0;
			end
			else if (rise && bitcnt < 6'(fdiv_pkg::FRAME_BITS))
			begin
				shreg <= {shreg[31:0], sdi_m[1]};
				bitcnt <= bitcnt + 6'h01;
				// Header order is write/read flag, register, chip address.
				// chip field captured
				if (bitcnt == 6'(fdiv_pkg::HDR_BITS - 1))
				begin
					fr.hdr_stb <= 1'b1;
					fr.rd <= shreg[8];
					fr.regad <= shreg[7:2];
					fr.chip <= {shreg[1:0], sdi_m[1]};
				end
				if (bitcnt == 6'(fdiv_pkg::FRAME_BITS - 1) && !fr.rd)
				begin
					fr.wr_stb <= 1'b1;
					fr.wdata <= {shreg[22:0], sdi_m[1]};
				end
			end
		end
	end

	// Read data changes on falling clock so the host samples it stable.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			txsh <= 24'h000000;
			fr.sdo <= 1'b0;
		end
		else if (fr.hdr_stb)
			txsh <= fr.rdata;
		else if (fall && fr.rd && bitcnt >= 6'(fdiv_pkg::HDR_BITS))
		begin
			fr.sdo <= txsh[23];
			txsh <= {txsh[22:0], 1'b0};
		end
	end
endmodule

// ==== core/ratio_divider.sv ====
`timescale 1ns/1ps
module ratio_divider
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic frac_i,
	input wire logic [19:0] ratio_i,
	input wire logic [23:0] frac_word_i,
	input wire logic [2:0] pw_i,
	output logic pos_o,
	output logic neg_o
);
	logic [20:0] lim, period, cnt;
	logic [23:0] acc;
	logic carry, raw, rt, wrap;
	logic [3:0] hi_cnt;

	always_comb
	begin
		lim = {1'b0, ratio_i};
		if (frac_i)
		begin
			if (lim < fdiv_pkg::FRAC_MIN)
				lim = fdiv_pkg::FRAC_MIN;
			else if (lim > fdiv_pkg::FRAC_MAX)
				lim = fdiv_pkg::FRAC_MAX;
		end
		else if (lim < fdiv_pkg::INT_MIN)
			lim = fdiv_pkg::INT_MIN;
	end

	assign period = lim + {20'h0, carry};
	assign wrap = cnt >= period - 21'h1;

	// First-order accumulation; its carry stretches one output period.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt <= 21'h0;
			acc <= 24'h000000;
			carry <= 1'b0;
		end
		else if (!run_i)
		begin
			cnt <= 21'h0;
			carry <= 1'b0;
		end
		else if (wrap)
		begin
			cnt <= 21'h0;
			{carry, acc} <= frac_i ? {1'b0, acc} + {1'b0, frac_word_i}
				: 25'h0;
		end
		else
			cnt <= cnt + 21'h1;
	end

	// only the leading edge passes the retime stage
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			raw <= 1'b0;
			rt <= 1'b0;
		end
		else
		begin
			raw <= run_i && cnt <= {18'h0, pw_i} + 21'h1;
			rt <= raw;
		end
	end

	// The trailing edge follows raw directly and is not cleaned.
	assign pos_o = raw & rt;
	assign neg_o = ~pos_o;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			hi_cnt <= 4'h0;
		else
			hi_cnt <= pos_o ? hi_cnt + 4'h1 : 4'h0;
	end

	ratio_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		lim >= fdiv_pkg::INT_MIN && (!frac_i ||
		(lim >= fdiv_pkg::FRAC_MIN && lim <= fdiv_pkg::FRAC_MAX)))
		else $error("effective ratio out of range");
	pulse_width_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(pos_o) && pw_i == $past(pw_i, 10) && run_i |->
		hi_cnt == {1'b0, pw_i} + 4'h1)
		else $error("pulse width differs from setting");
	retimed_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(pos_o) |-> $past(raw) && $fell(neg_o))
		else $error("leading edge not retimed");
	pulse_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(pos_o) && frac_i);
endmodule

// ==== core/frac_div_top.sv ====
`timescale 1ns/1ps
module frac_div_top
(
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic SPI_SCK_I,
	input wire logic SPI_SDI_I,
	input wire logic SPI_CSN_I,
	input wire logic ADDR_STRAP_BIT0_I,
	input wire logic ADDR_STRAP_BIT1_I,
	input wire logic ADDR_STRAP_BIT2_I,
	output logic SDO_O,
	output logic SDO_OE_O,
	output logic DIV_OUT_POS_O,
	output logic DIV_OUT_NEG_O
);
	logic [1:0] rst_sync;
	logic rst_n;
	logic [2:0] strap_m, strap_s;
	logic [2:0] strap_addr;
	logic latch_pend;
	logic [1:0] latch_cnt;
	logic soft_rst;
	logic [2:0] pw;
	logic [19:0] int_ratio;
	logic [13:0] refdiv;
	logic [23:0] frac_word;
	logic [2:0] comp_addr;
	logic [1:0] mode;
	logic own_hit, comp_en, comp_hit;
	logic own_wr, comp_wr;

	frame_if fr ();

	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	assign rst_n = rst_sync[1];

	// The pins have internal pull-ups, so open pins arrive here as one.
	// strap pins to address bits
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_m <= fdiv_pkg::STRAP_RST;
			strap_s <= fdiv_pkg::STRAP_RST;
		end
		else
		begin
			strap_m <= {ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I,
				ADDR_STRAP_BIT0_I};
			strap_s <= strap_m;
		end
	end

	// Capture stays open for three edges, so the last one sees pin values
	// that have passed both synchroniser stages rather than its reset value.
	// latched only after a reset
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			latch_cnt <= fdiv_pkg::STRAP_WAIT;
		else if (soft_rst)
			latch_cnt <= fdiv_pkg::STRAP_WAIT;
		else if (latch_cnt != 2'h0)
			latch_cnt <= latch_cnt - 2'h1;
	end

	assign latch_pend = latch_cnt != 2'h0;

	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			strap_addr <= fdiv_pkg::STRAP_RST;
		else if (latch_pend)
			strap_addr <= strap_s;
	end

	// own frame only on address match
	assign own_hit = fr.chip == strap_addr;
	assign comp_en = comp_addr != strap_addr;
	assign comp_hit = comp_en && fr.chip == comp_addr;
	assign own_wr = fr.wr_stb && own_hit;
	assign comp_wr = fr.wr_stb && comp_hit &&
		fr.regad == fdiv_pkg::COMP_REFDIV_REG;

	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			soft_rst <= 1'b0;
		else
			soft_rst <= own_wr && fr.regad == fdiv_pkg::REG_IDENT &&
				fr.wdata[fdiv_pkg::SOFT_RST_BIT];
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			pw <= fdiv_pkg::PW_RST;
		else if (soft_rst)
			pw <= fdiv_pkg::PW_RST;
		else if (own_wr && fr.regad == fdiv_pkg::REG_IDENT)
			pw <= fr.wdata[fdiv_pkg::PW_LSB +: fdiv_pkg::PW_W];
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			int_ratio <= fdiv_pkg::INT_RST;
		else if (soft_rst)
			int_ratio <= fdiv_pkg::INT_RST;
		else if (own_wr && fr.regad == fdiv_pkg::REG_INT)
			int_ratio <= fr.wdata[fdiv_pkg::INT_W-1:0];
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			refdiv <= fdiv_pkg::REFDIV_RST;
		else if (soft_rst)
			refdiv <= fdiv_pkg::REFDIV_RST;
		else if (comp_wr ||
			(own_wr && fr.regad == fdiv_pkg::REG_REFDIV))
			refdiv <= fr.wdata[fdiv_pkg::REFDIV_W-1:0];
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			frac_word <= fdiv_pkg::FRAC_RST;
		else if (soft_rst)
			frac_word <= fdiv_pkg::FRAC_RST;
		else if (own_wr && fr.regad == fdiv_pkg::REG_FRAC)
			frac_word <= fr.wdata;
	end

	// Loading the strap value here keeps watching off until software
	// names a real companion.
	// companion address register
	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			comp_addr <= fdiv_pkg::STRAP_RST;
		else if (latch_pend)
			comp_addr <= strap_s;
		else if (own_wr && fr.regad == fdiv_pkg::REG_COMP)
			comp_addr <= fr.wdata[2:0];
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			mode <= fdiv_pkg::MODE_RST;
		else if (soft_rst)
			mode <= fdiv_pkg::MODE_RST;
		else if (own_wr && fr.regad == fdiv_pkg::REG_MODE)
			mode <= fr.wdata[1:0];
	end

	always_comb
	begin
		case (fr.regad)
			fdiv_pkg::REG_IDENT:
				fr.rdata = {9'h0, pw, 9'h0, strap_addr};
			fdiv_pkg::REG_REFDIV:
				fr.rdata = {10'h0, refdiv};
			fdiv_pkg::REG_INT:
				fr.rdata = {4'h0, int_ratio};
			fdiv_pkg::REG_FRAC:
				fr.rdata = frac_word;
			fdiv_pkg::REG_COMP:
				fr.rdata = {21'h0, comp_addr};
			fdiv_pkg::REG_MODE:
				fr.rdata = {22'h0, mode};
			default:
				fr.rdata = 24'h000000;
		endcase
	end

	// drive the shared data line only when addressed
	assign SDO_OE_O = fr.active && fr.rd && own_hit;
	assign SDO_O = fr.sdo;

	spi_frame_rx u_rx
	(
		.clk_i(CORE_CLK_I),
		.rst_n_i(rst_n),
		.sck_i(SPI_SCK_I),
		.sdi_i(SPI_SDI_I),
		.csn_i(SPI_CSN_I),
		.fr(fr)
	);

	ratio_divider u_div
	(
		.clk_i(CORE_CLK_I),
		.rst_n_i(rst_n),
		.run_i(mode[fdiv_pkg::MODE_RUN_BIT]),
		.frac_i(mode[fdiv_pkg::MODE_FRAC_BIT]),
		.ratio_i(int_ratio),
		.frac_word_i(frac_word),
		.pw_i(pw),
		.pos_o(DIV_OUT_POS_O),
		.neg_o(DIV_OUT_NEG_O)
	);

	strap_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		!$past(latch_pend) |-> $stable(strap_addr))
		else $error("strap address moved outside reset");
	strap_take_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		latch_pend |=> strap_addr == $past(strap_s))
		else $error("strap address not captured");
	comp_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		fr.wr_stb && comp_addr == strap_addr && !own_hit |=>
		$stable(refdiv))
		else $error("disabled companion watch changed register");
	foreign_ign_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		fr.wr_stb && !own_hit && !comp_hit |=> $stable(int_ratio)
		&& $stable(pw) && $stable(comp_addr) && $stable(refdiv)
		&& $stable(mode) && $stable(frac_word))
		else $error("foreign frame changed a register");
	comp_follow_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		comp_wr && !soft_rst |=> refdiv == $past(fr.wdata[13:0]))
		else $error("companion write not mirrored");
	int_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		own_wr && fr.regad == fdiv_pkg::REG_INT && !soft_rst |=>
		int_ratio == $past(fr.wdata[19:0]))
		else $error("integer ratio write lost");
	comp_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		own_wr && fr.regad == fdiv_pkg::REG_COMP && !latch_pend |=>
		comp_addr == $past(fr.wdata[2:0]))
		else $error("companion address write lost");
	sdo_own_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		SDO_OE_O |-> fr.chip == strap_addr && fr.rd && fr.active)
		else $error("data line driven for another device");
	pw_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		own_wr && fr.regad == fdiv_pkg::REG_IDENT && !soft_rst |=>
		pw == $past(fr.wdata[14:12]))
		else $error("pulse width write lost");

	own_write_c: cover property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		own_wr && fr.regad == fdiv_pkg::REG_INT);
	comp_write_c: cover property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		comp_wr);
	own_read_c: cover property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		$rose(SDO_OE_O));
	foreign_c: cover property (@(posedge CORE_CLK_I) disable iff (!rst_n)
		fr.wr_stb && !own_hit && !comp_hit);
endmodule

// ==== test/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model
(
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [33:0] word_i,
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	output logic sck_o,
	output logic sdi_o,
	output logic csn_o,
	output logic busy_o,
	output logic [23:0] rdata_o
);
	logic line;
	// A released data line is assumed to sit at its board pull-up level.
	assign line = sdo_oe_i ? sdo_i : 1'b1;
	initial
	begin
		sck_o = 1'b0;
		sdi_o = 1'b1;
		csn_o = 1'b1;
		busy_o = 1'b0;
		rdata_o = 24'h000000;
		forever
		begin
			@(negedge clk_i);
			if (start_i === 1'b1)
			begin
				busy_o = 1'b1;
				csn_o = 1'b0;
				for (int i = 33; i >= 0; i--)
				begin
					sdi_o = word_i[i];
					repeat (5) @(negedge clk_i);
					sck_o = 1'b1;
					if (i < 24)
						rdata_o = {rdata_o[22:0], line};
					repeat (5) @(negedge clk_i);
					sck_o = 1'b0;
				end
				repeat (5) @(negedge clk_i);
				csn_o = 1'b1;
				sdi_o = ~sdi_o;
				repeat (8) @(negedge clk_i);
				busy_o = 1'b0;
			end
		end
	end
endmodule

// ==== test/frac_divider_spi_addressing_bench.sv ====
`timescale 1ns/1ps
module frac_divider_spi_addressing_bench;
	logic clk;
	logic rst_n;
	logic start;
	logic sck;
	logic sdi;
	logic csn;
	logic sdo;
	logic sdo_oe;
	logic pos;
	logic neg;
	logic busy;
	logic oe_seen;
	logic [2:0] strap;
	logic [33:0] word;
	logic [23:0] rdata;
	logic [23:0] got;
	int fail_count;
	int checks;
	int cycles;
	frac_div_top dut_u
	(
		.CORE_CLK_I(clk),
		.RESETN_I(rst_n),
		.SPI_SCK_I(sck),
		.SPI_SDI_I(sdi),
		.SPI_CSN_I(csn),
		.ADDR_STRAP_BIT0_I(strap[0]),
		.ADDR_STRAP_BIT1_I(strap[1]),
		.ADDR_STRAP_BIT2_I(strap[2]),
		.SDO_O(sdo),
		.SDO_OE_O(sdo_oe),
		.DIV_OUT_POS_O(pos),
		.DIV_OUT_NEG_O(neg)
	);
	spi_host_model host_u
	(
		.clk_i(clk),
		.start_i(start),
		.word_i(word),
		.sdo_i(sdo),
		.sdo_oe_i(sdo_oe),
		.sck_o(sck),
		.sdi_o(sdi),
		.csn_o(csn),
		.busy_o(busy),
		.rdata_o(rdata)
	);
	initial
	begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end
	// The ceiling allows about twenty frames plus the divider runs.
	always @(posedge clk)
	begin
		cycles++;
		if (sdo_oe === 1'b1)
			oe_seen = 1'b1;
		if (cycles == 40000)
		begin
			fail_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("fail_count=%0d checks=%0d", fail_count, checks);
		if (fail_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp24(input logic [23:0] exp, input logic [23:0] act);
		checks++;
		if (act !== exp)
		begin
			fail_count++;
			$display("Error at %0t: read %h expected %h", $time, act, exp);
		end
	endtask
	task automatic cmp_cnt(input int exp, input int act);
		checks++;
		if (act != exp)
		begin
			fail_count++;
			$display("Error at %0t: count %0d expected %0d", $time, act, exp);
		end
	endtask
	task automatic frame(input logic rd, input logic [5:0] ra,
		input logic [2:0] chip, input logic [23:0] d);
		int n;
		n = 0;
		@(negedge clk);
		word <= {rd, ra, chip, d};
		start <= 1'b1;
		@(negedge clk);
		start <= 1'b0;
		@(negedge clk);
		while (busy === 1'b1 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
		got = rdata;
	endtask
	task automatic do_reset();
		@(negedge clk);
		rst_n <= 1'b0;
		repeat (5) @(negedge clk);
		rst_n <= 1'b1;
		repeat (10) @(negedge clk);
	endtask
	task automatic measure(output int per, output int hi, output int bad);
		logic last;
		int n;
		per = 0;
		hi = 1;
		bad = 0;
		n = 0;
		last = 1'b1;
		while (!(last === 1'b0 && pos === 1'b1) && n < 3000)
		begin
			last = pos;
			@(posedge clk);
			#1;
			n++;
		end
		while (per < 3000)
		begin
			last = pos;
			@(posedge clk);
			#1;
			per++;
			if (neg !== ~pos)
				bad++;
			if (last === 1'b0 && pos === 1'b1)
				break;
			if (pos === 1'b1)
				hi++;
		end
	endtask
	task automatic t_strap();
		frame(1'b1, fdiv_pkg::REG_IDENT, 3'h5, 24'h000000);
		cmp24(24'h003005, got);
		@(negedge clk);
		strap <= 3'h2;
		frame(1'b1, fdiv_pkg::REG_IDENT, 3'h5, 24'h000000);
		cmp24(24'h003005, got);
		do_reset();
		frame(1'b1, fdiv_pkg::REG_IDENT, 3'h2, 24'h000000);
		cmp24(24'h003002, got);
		@(negedge clk);
		strap <= 3'h5;
		do_reset();
	endtask
	task automatic t_foreign();
		// No setting reaches 40% duty at these ratios, so take the widest.
		// widest pulse chosen
		frame(1'b0, fdiv_pkg::REG_IDENT, 3'h5, 24'h007000);
		frame(1'b1, fdiv_pkg::REG_IDENT, 3'h5, 24'h000000);
		cmp24(24'h007005, got);
		oe_seen = 1'b0;
		frame(1'b0, fdiv_pkg::REG_IDENT, 3'h3, 24'h001000);
		frame(1'b1, fdiv_pkg::REG_IDENT, 3'h3, 24'h000000);
		cmp24(24'h000000, {23'h0, oe_seen});
		frame(1'b1, fdiv_pkg::REG_IDENT, 3'h5, 24'h000000);
		cmp24(24'h007005, got);
	endtask
	task automatic t_companion();
		frame(1'b0, fdiv_pkg::REG_COMP, 3'h5, 24'h000002);
		frame(1'b1, fdiv_pkg::REG_COMP, 3'h5, 24'h000000);
		cmp24(24'h000002, got);
		frame(1'b0, fdiv_pkg::COMP_REFDIV_REG, 3'h2, 24'h000abc);
		frame(1'b1, fdiv_pkg::REG_REFDIV, 3'h5, 24'h000000);
		cmp24(24'h000abc, got);
		frame(1'b0, fdiv_pkg::REG_COMP, 3'h5, 24'h000005);
		frame(1'b0, fdiv_pkg::COMP_REFDIV_REG, 3'h2, 24'h000123);
		frame(1'b1, fdiv_pkg::REG_REFDIV, 3'h5, 24'h000000);
		cmp24(24'h000abc, got);
	endtask
	task automatic t_divider();
		logic [1:0] modes [3] = '{2'h2, 2'h2, 2'h3};
		int ratios [3] = '{32, 1000, 36};
		int per;
		int hi;
		int bad;
		for (int i = 0; i < 3; i++)
		begin
			frame(1'b0, fdiv_pkg::REG_MODE, 3'h5, {22'h0, modes[i]});
			frame(1'b0, fdiv_pkg::REG_INT, 3'h5, 24'(ratios[i]));
			measure(per, hi, bad);
			measure(per, hi, bad);
			cmp_cnt(ratios[i], per);
			cmp_cnt(8, hi);
			cmp_cnt(0, bad);
		end
	endtask
	initial
	begin
		rst_n = 1'b0;
		start = 1'b0;
		word = 34'h000000000;
		strap = 3'h5;
		oe_seen = 1'b0;
		got = 24'h000000;
		fail_count = 0;
		checks = 0;
		cycles = 0;
		do_reset();
		t_strap();
		t_foreign();
		t_companion();
		t_divider();
		final_report();
	end
endmodule
